/* File: e1_loopback_alarm_control.sv */
// Loopback, alarm insertion and clock selection for one E1 channel.
// Assumes framer, formatter and counters on I_CLK; line pins asynchronous.
`timescale 1ns/10ps
`default_nettype none
module e1_loopback_alarm_control
	import e1_lac_pkg::*;
#(
	parameter int MF_SHORT = MF_SHORT_CYC,
	parameter int MF_LONG  = MF_LONG_CYC,
	parameter int FR_SLOW  = FRAMES_PER_S,
	parameter int FR_FAST  = FRAMES_FAST,
	parameter int CLK_LOSS = TXCLK_LOSS_CYC
) (
	input  wire logic                   I_CLK,
	input  wire logic                   I_RST_N,
	input  wire logic [7:0]             I_ADDR,
	input  wire logic [7:0]             I_WDATA,
	input  wire logic                   I_WR,
	input  wire logic                   I_RD,
	output logic      [7:0]             O_RDATA,
	input  wire logic                   I_FRAMER_LOOP_ENABLE,
	input  wire e1_lac_pkg::line_pair_s I_RX_LINE,
	input  wire logic                   I_TX_CLK_IN,
	input  wire logic                   I_REC_CLK,
	input  wire e1_lac_pkg::line_pair_s I_TX_FMT,
	input  wire logic                   I_RX_SER_DATA,
	input  wire e1_lac_pkg::rx_alarm_s  I_RX_ALARM,
	input  wire logic                   I_CRC4_EN,
	input  wire logic                   I_FRAME_TICK,
	input  wire logic                   I_TX_CHAN_STB,
	input  wire logic [4:0]             I_TX_CHAN_NUM,
	input  wire logic [7:0]             I_TX_CHAN_DATA,
	output e1_lac_pkg::line_pair_s      O_TX_LINE,
	output e1_lac_pkg::line_pair_s      O_RX_FRM,
	output logic                        O_RX_CLK_OUT,
	output logic                        O_RX_SERIAL_OUT,
	output logic                        O_TX_CLK_FROM_REC,
	output logic                        O_SEND_AIS,
	output logic                        O_SEND_FAR_ALARM,
	output logic                        O_CARRIER_LOSS,
	output logic                        O_CNT_LATCH,
	output logic                        O_COUNT_CV,
	output logic                        O_LOCAL_LOOP,
	output logic                        O_IRQ
);
	import e1_lac_pkg::*;

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	// ****************************************************************
	// Pin synchronisers and line clock activity
	// ****************************************************************
	logic [3:0] pins_s;
	line_pair_s rx_s;
	logic       tx_clk_s;
	logic       rec_clk_s;
	logic       rec_d_r;
	logic       tx_d_r;
	logic       bit_stb;
	logic       carrier_loss;
	logic [6:0] idle_r;
	logic       clk_lost_r;

	e1_lac_sync #(.W(4)) u_sync (
		.i_clk   (I_CLK),
		.i_rst_n (I_RST_N),
		.i_d     ({I_RX_LINE, I_TX_CLK_IN, I_REC_CLK}),
		.o_q     (pins_s)
	);
	assign rx_s      = pins_s[3:2];
	assign tx_clk_s  = pins_s[1];
	assign rec_clk_s = pins_s[0];
	assign bit_stb   = rec_clk_s & ~rec_d_r;

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			rec_d_r <= 1'b0;
			tx_d_r  <= 1'b0;
		end else begin
			rec_d_r <= rec_clk_s;
			tx_d_r  <= tx_clk_s;
		end
	end

	// A transmit clock with no edge for more than CLK_LOSS cycles counts as stopped.
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			idle_r     <= '0;
			clk_lost_r <= 1'b0;
		end else if (tx_clk_s != tx_d_r) begin
			idle_r     <= '0;
			clk_lost_r <= 1'b0;
		end else if (idle_r != 7'(CLK_LOSS)) begin
			idle_r <= idle_r + 7'h01;
		end else begin
			clk_lost_r <= 1'b1;
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	logic [7:0] ctl2_r;
	logic [7:0] ctl3_r;
	logic [7:0] act2_r;
	logic [7:0] act3_r;
	logic [7:0] mon_r;
	logic [EV_W-1:0] stat_r;
	logic [EV_W-1:0] mask_r;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] stat_nxt;
	mf_state_e       mf_st;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			ctl2_r <= CTL_RST;
			ctl3_r <= CTL_RST;
			mask_r <= '0;
		end else if (I_WR) begin
			if (hit(I_ADDR, REG_COUNTER_ALARM_CLOCK_CONTROL))
				ctl2_r <= I_WDATA;
			else if (hit(I_ADDR, REG_LOOPBACK_LINE_MONITOR_CONTROL))
				ctl3_r <= I_WDATA;
			else if (hit(I_ADDR, REG_EVENT_MASK))
				mask_r <= I_WDATA[EV_W-1:0];
		end
	end

	// Settings switch only at a frame boundary so no frame is half changed.
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			act2_r <= CTL_RST;
			act3_r <= CTL_RST;
		end else if (I_FRAME_TICK) begin
			act2_r <= ctl2_r;
			act3_r <= ctl3_r;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_RDATA <= '0;
		end else if (!I_RD) begin
			O_RDATA <= '0;
		end else if (hit(I_ADDR, REG_COUNTER_ALARM_CLOCK_CONTROL)) begin
			O_RDATA <= ctl2_r;
		end else if (hit(I_ADDR, REG_LOOPBACK_LINE_MONITOR_CONTROL)) begin
			O_RDATA <= ctl3_r;
		end else if (hit(I_ADDR, REG_TX_MONITOR)) begin
			O_RDATA <= mon_r;
		end else if (hit(I_ADDR, REG_EVENT_STATUS)) begin
			O_RDATA <= {4'h0, stat_r};
		end else if (hit(I_ADDR, REG_EVENT_MASK)) begin
			O_RDATA <= {4'h0, mask_r};
		end else if (hit(I_ADDR, REG_LIVE_STATE)) begin
			O_RDATA <= {4'h0, mf_st == MF_LOST, clk_lost_r,
				carrier_loss, I_RX_ALARM.frame_loss};
		end else begin
			O_RDATA <= '0;
		end
	end

	// The monitor copies the selected channel as each channel goes by.
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N)
			mon_r <= '0;
		else if (I_TX_CHAN_STB && I_TX_CHAN_NUM == act3_r[MON_MSB:0])
			mon_r <= I_TX_CHAN_DATA;
	end

	// ****************************************************************
	// Carrier loss, error counter interval and multiframe search
	// ****************************************************************
	e1_lac_zero_run u_zero (
		.i_clk     (I_CLK),
		.i_rst_n   (I_RST_N),
		.i_bit_stb (bit_stb),
		.i_mark    (rx_s.pos | rx_s.neg),
		.i_long    (act2_r[B_CARRIER]),
		.o_loss    (carrier_loss)
	);

	logic [13:0] frm_cnt_r;
	logic [13:0] frm_lim;
	assign frm_lim = act2_r[B_INTERVAL] ? 14'(FR_FAST) : 14'(FR_SLOW);

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			frm_cnt_r   <= '0;
			O_CNT_LATCH <= 1'b0;
		end else begin
			O_CNT_LATCH <= 1'b0;
			if (I_FRAME_TICK) begin
				if (frm_cnt_r >= frm_lim - 14'h0001) begin
					frm_cnt_r   <= '0;
					O_CNT_LATCH <= 1'b1;
				end else begin
					frm_cnt_r <= frm_cnt_r + 14'h0001;
				end
			end
		end
	end

	logic [24:0] mf_cnt_r;
	logic        mf_search;
	assign mf_search = I_CRC4_EN & I_RX_ALARM.fas_sync & ~I_RX_ALARM.mf_sync;

	// Once the long limit passes, only multiframe sync or CRC4 off ends it.
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			mf_st    <= MF_IDLE;
			mf_cnt_r <= '0;
		end else begin
			case (mf_st)
			MF_IDLE: begin
				mf_cnt_r <= '0;
				if (mf_search)
					mf_st <= MF_WAIT;
			end
			MF_WAIT: begin
				mf_cnt_r <= mf_cnt_r + 25'h1;
				if (!mf_search)
					mf_st <= MF_IDLE;
				else if (mf_cnt_r == 25'(MF_SHORT - 2))
					mf_st <= MF_LATE;
			end
			MF_LATE: begin
				mf_cnt_r <= mf_cnt_r + 25'h1;
				if (!mf_search)
					mf_st <= MF_IDLE;
				else if (mf_cnt_r == 25'(MF_LONG - 2))
					mf_st <= MF_LOST;
			end
			MF_LOST: begin
				if (I_RX_ALARM.mf_sync || !I_CRC4_EN)
					mf_st <= MF_IDLE;
			end
			default: mf_st <= MF_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Alarms, clock selection and data routing
	// ****************************************************************
	logic rx_bad;
	logic ones_ph_r;
	logic [4:0] div_r;
	assign rx_bad = I_RX_ALARM.frame_loss | I_RX_ALARM.ais_rx | carrier_loss;

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_SEND_AIS        <= 1'b0;
			O_SEND_FAR_ALARM  <= 1'b0;
			O_CARRIER_LOSS    <= 1'b0;
			O_COUNT_CV        <= 1'b0;
			O_TX_CLK_FROM_REC <= 1'b0;
		end else begin
			O_SEND_AIS <= act2_r[B_AUTO_AIS] & rx_bad;
			O_SEND_FAR_ALARM <= act2_r[B_AUTO_FAR] & (rx_bad
				| mf_st == MF_LATE | mf_st == MF_LOST);
			O_CARRIER_LOSS <= carrier_loss;
			O_COUNT_CV <= act2_r[B_VIOL_KIND];
			O_TX_CLK_FROM_REC <= act2_r[B_CLK_SRC]
				| (act2_r[B_CLK_FB] & clk_lost_r);
		end
	end

	// All ones alternate polarity at the line bit rate, like AMI marks.
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			div_r     <= '0;
			ones_ph_r <= 1'b0;
		end else if (div_r == 5'(ONES_DIV - 1)) begin
			div_r     <= '0;
			ones_ph_r <= ~ones_ph_r;
		end else begin
			div_r <= div_r + 5'h01;
		end
	end

	// Line all ones wins over remote loop, which wins over formatter data.
	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_TX_LINE <= '0;
		end else if (act3_r[B_ALL_ONES]) begin
			O_TX_LINE <= '{pos: ones_ph_r, neg: ~ones_ph_r};
		end else if (act3_r[B_LINE_LOOP]) begin
			O_TX_LINE <= rx_s;
		end else begin
			O_TX_LINE <= I_TX_FMT;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			O_RX_FRM        <= '0;
			O_RX_CLK_OUT    <= 1'b0;
			O_RX_SERIAL_OUT <= 1'b0;
			O_LOCAL_LOOP    <= 1'b0;
		end else begin
			if (I_FRAMER_LOOP_ENABLE | act3_r[B_NEAR_LOOP])
				O_RX_FRM <= I_TX_FMT;
			else
				O_RX_FRM <= rx_s;
			O_RX_CLK_OUT <= I_FRAMER_LOOP_ENABLE ? tx_clk_s
				: rec_clk_s;
			O_RX_SERIAL_OUT <= I_RX_SER_DATA | (act2_r[B_RX_FORCE]
				& I_RX_ALARM.frame_loss);
			O_LOCAL_LOOP <= act3_r[B_NEAR_LOOP];
		end
	end

	// ****************************************************************
	// Event status and interrupt
	// ****************************************************************
	logic cl_d_r;
	logic lost_d_r;
	logic mfl_d_r;
	assign events = {O_CNT_LATCH, mf_st == MF_LOST & ~mfl_d_r,
		clk_lost_r & ~lost_d_r, carrier_loss & ~cl_d_r};

	// A new event wins over a clear written in the same cycle.
	always_comb begin
		stat_nxt = stat_r;
		if (I_WR && hit(I_ADDR, REG_EVENT_STATUS))
			stat_nxt = stat_r & ~I_WDATA[EV_W-1:0];
		stat_nxt = stat_nxt | events;
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RST_N) begin
			stat_r   <= '0;
			O_IRQ    <= 1'b0;
			cl_d_r   <= 1'b0;
			lost_d_r <= 1'b0;
			mfl_d_r  <= 1'b0;
		end else begin
			stat_r   <= stat_nxt;
			O_IRQ    <= |(stat_nxt & mask_r);
			cl_d_r   <= carrier_loss;
			lost_d_r <= clk_lost_r;
			mfl_d_r  <= mf_st == MF_LOST;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_loop_rx_route: assert property (
		I_FRAMER_LOOP_ENABLE |=> O_RX_FRM == $past(I_TX_FMT))
		else $error("framer loop did not route formatter data");
	a_loop_tx_normal: assert property (
		I_FRAMER_LOOP_ENABLE && !act3_r[B_LINE_LOOP] && !act3_r[B_ALL_ONES]
		|=> O_TX_LINE == $past(I_TX_FMT))
		else $error("framer loop disturbed line outputs");
	a_loop_rx_clock: assert property (
		I_FRAMER_LOOP_ENABLE |=> O_RX_CLK_OUT == $past(tx_clk_s))
		else $error("framer loop clock not from transmit clock");
	a_cnt_latch: assert property (
		I_FRAME_TICK && frm_cnt_r == frm_lim - 14'h0001
		|=> O_CNT_LATCH ##1 !O_CNT_LATCH)
		else $error("counter latch missing at interval end");
	a_auto_ais: assert property (
		act2_r[B_AUTO_AIS] && I_RX_ALARM.ais_rx |=> O_SEND_AIS)
		else $error("auto AIS not sent");
	a_mf_long: assert property (
		act2_r[B_AUTO_FAR] && mf_st == MF_LOST |=> O_SEND_FAR_ALARM)
		else $error("far alarm not continuous after long search");
	a_rx_force: assert property (
		act2_r[B_RX_FORCE] && I_RX_ALARM.frame_loss |=> O_RX_SERIAL_OUT)
		else $error("receive serial not forced high");
	a_no_fallback: assert property (
		!act2_r[B_CLK_SRC] && !act2_r[B_CLK_FB] |=> !O_TX_CLK_FROM_REC)
		else $error("transmit clock switched without fallback");
	a_clk_source: assert property (
		act2_r[B_CLK_SRC] |=> O_TX_CLK_FROM_REC)
		else $error("source select ignored");
	a_line_ones: assert property (
		act3_r[B_ALL_ONES] |=> O_TX_LINE.pos != O_TX_LINE.neg)
		else $error("line all ones not driven");
	a_line_loop_tx: assert property (
		act3_r[B_LINE_LOOP] && !act3_r[B_ALL_ONES]
		|=> O_TX_LINE == $past(rx_s))
		else $error("remote loop not retransmitting line data");
	a_ctl_readback: assert property (
		I_WR && I_ADDR == REG_COUNTER_ALARM_CLOCK_CONTROL
		##1 I_RD && I_ADDR == REG_COUNTER_ALARM_CLOCK_CONTROL
		|=> O_RDATA == $past(I_WDATA, 2))
		else $error("control register read back wrong");

endmodule
`default_nettype wire

/* File: e1_lac_pkg.sv */
// Constants and types for one E1 loopback, alarm and clock control channel.
// Assumes a single 50 MHz system clock and an 8-bit register port.
`default_nettype none
package e1_lac_pkg;
	localparam int CLK_HZ  = 50_000_000;
	localparam int LINE_HZ = 2_048_000;
	localparam int MS_PER_S = 1000;
	localparam int MF_SHORT_MS = 128;
	localparam int MF_LONG_MS  = 400;
	localparam int MF_SHORT_CYC = MF_SHORT_MS * (CLK_HZ / MS_PER_S);
	localparam int MF_LONG_CYC  = MF_LONG_MS * (CLK_HZ / MS_PER_S);
	localparam int ONES_DIV = CLK_HZ / LINE_HZ;
	localparam int TXCLK_LOSS_CYC = 64;
	localparam int FRAMES_FAST = 500;
	localparam int FRAMES_PER_S = 8000;
	localparam int ZERO_SHORT = 255;
	localparam int ZERO_LONG  = 2048;
	localparam logic [7:0] REG_COUNTER_ALARM_CLOCK_CONTROL = 8'h13;
	localparam logic [7:0] REG_LOOPBACK_LINE_MONITOR_CONTROL = 8'h14;
	localparam logic [7:0] REG_TX_MONITOR = 8'h20;
	localparam logic [7:0] REG_EVENT_STATUS = 8'h21;
	localparam logic [7:0] REG_EVENT_MASK = 8'h22;
	localparam logic [7:0] REG_LIVE_STATE = 8'h23;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam int B_INTERVAL  = 7;
	localparam int B_VIOL_KIND = 6;
	localparam int B_AUTO_AIS  = 5;
	localparam int B_AUTO_FAR  = 4;
	localparam int B_RX_FORCE  = 3;
	localparam int B_CLK_FB    = 2;
	localparam int B_CARRIER   = 1;
	localparam int B_CLK_SRC   = 0;
	localparam int B_LINE_LOOP = 7;
	localparam int B_NEAR_LOOP = 6;
	localparam int B_ALL_ONES  = 5;
	localparam int MON_MSB = 4;
	localparam int EV_W = 4;
	typedef struct packed {
		logic pos;
		logic neg;
	} line_pair_s;
	typedef struct packed {
		logic frame_loss;
		logic ais_rx;
		logic fas_sync;
		logic mf_sync;
	} rx_alarm_s;
	typedef enum logic [1:0] {
		MF_IDLE = 2'b00,
		MF_WAIT = 2'b01,
		MF_LATE = 2'b11,
		MF_LOST = 2'b10
	} mf_state_e;
endpackage
`default_nettype wire

/* File: e1_lac_sync.sv */
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to the clock.
`timescale 1ns/10ps
`default_nettype none
module e1_lac_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_r <= '0;
			o_q    <= '0;
		end else begin
			meta_r <= i_d;
			o_q    <= meta_r;
		end
	end
endmodule
`default_nettype wire

/* File: e1_lac_zero_run.sv */
// Consecutive-zero counter that declares receive carrier loss.
// Assumes one bit strobe per received line bit, on the system clock.
`timescale 1ns/10ps
`default_nettype none
module e1_lac_zero_run
	import e1_lac_pkg::*;
#(
	parameter int SHORT = ZERO_SHORT,
	parameter int LONG  = ZERO_LONG
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_bit_stb,
	input  wire logic i_mark,
	input  wire logic i_long,
	output logic      o_loss
);
	logic [11:0] cnt_r;
	logic [11:0] thr;
	assign thr = i_long ? 12'(LONG) : 12'(SHORT);
	// The count saturates so a dead line holds loss without wrapping.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cnt_r  <= '0;
			o_loss <= 1'b0;
		end else if (i_bit_stb) begin
			if (i_mark) begin
				cnt_r  <= '0;
				o_loss <= 1'b0;
			end else begin
				if (cnt_r < thr)
					cnt_r <= cnt_r + 12'h001;
				o_loss <= (cnt_r + 12'h001) >= thr;
			end
		end
	end
	a_mark_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_bit_stb && i_mark |=> !o_loss)
		else $error("carrier loss held after a mark");
endmodule
`default_nettype wire

/* File: e1_lac_line_model.sv */
// Behavioural line side: recovered clock, transmit clock and line marks.
// Assumes the bench picks all zeros or alternating marks, and clock stop.
`timescale 1ns/10ps
`default_nettype none
module e1_lac_line_model (
	input  wire logic            i_zeros,
	input  wire logic            i_tx_clk_run,
	output logic                 o_rec_clk,
	output logic                 o_tx_clk,
	output e1_lac_pkg::line_pair_s o_line
);
	import e1_lac_pkg::*;

	logic phase_r;

	initial begin
		o_rec_clk = 1'b0;
		o_tx_clk = 1'b0;
		o_line = '0;
		phase_r = 1'b0;
	end

	// Both clocks are unrelated in phase to the system clock; only the recovered clock is free running.
	always #97 o_rec_clk = ~o_rec_clk;

	// A stopped transmit clock simply freezes at its last level.
	always #103 if (i_tx_clk_run) o_tx_clk = ~o_tx_clk;

	always @(negedge o_rec_clk) begin
		phase_r <= ~phase_r;
		o_line <= i_zeros ? 2'b00 : {phase_r, ~phase_r};
	end
endmodule
`default_nettype wire

/* File: e1_loopback_alarm_control_bench.sv */
// Self-checking bench for the E1 loopback, alarm and clock control block.
// Assumes the line model file and the design files are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin \
	samples_checked++; \
	if ((a) !== (e)) begin \
		n_errors++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
	end \
end
module e1_loopback_alarm_control_bench;
	import e1_lac_pkg::*;

	localparam logic [7:0] CA = REG_COUNTER_ALARM_CLOCK_CONTROL;
	localparam logic [7:0] CL = REG_LOOPBACK_LINE_MONITOR_CONTROL;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tick_s = 1'b0;
	logic [7:0] addr = '0, wdata = '0, rdata, chan_data = '0;
	logic [4:0] chan_num = '0;
	logic chan_stb = 1'b0, rx_ser = 1'b0, crc4_en = 1'b0;
	logic frm_loop = 1'b0;
	logic zeros = 1'b0, tx_run = 1'b1, rec_clk, tx_clk;
	line_pair_s rx_line, tx_fmt = '0, tx_line, rx_frm;
	rx_alarm_s  rx_alarm = '0;
	logic rx_clk_out, ser_out, from_rec, send_ais, send_far, carrier;
	logic cnt_latch, count_cv, local_loop, irq;
	int n_errors = 0, samples_checked = 0, latches = 0;

	always #10 clk = ~clk;
	always @(posedge clk) if (cnt_latch === 1'b1) latches++;

	e1_lac_line_model e1_lac_line_model_inst (
		.i_zeros(zeros), .i_tx_clk_run(tx_run), .o_rec_clk(rec_clk),
		.o_tx_clk(tx_clk), .o_line(rx_line));

	e1_loopback_alarm_control #(.MF_SHORT(20), .MF_LONG(50), .FR_SLOW(20),
		.FR_FAST(5), .CLK_LOSS(64)) e1_loopback_alarm_control_inst (
		.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RX_LINE(rx_line),
		.I_FRAMER_LOOP_ENABLE(frm_loop),
		.I_TX_CLK_IN(tx_clk), .I_REC_CLK(rec_clk), .I_TX_FMT(tx_fmt),
		.I_RX_SER_DATA(rx_ser), .I_RX_ALARM(rx_alarm), .I_CRC4_EN(crc4_en),
		.I_FRAME_TICK(tick_s), .I_TX_CHAN_STB(chan_stb),
		.I_TX_CHAN_NUM(chan_num), .I_TX_CHAN_DATA(chan_data),
		.O_TX_LINE(tx_line), .O_RX_FRM(rx_frm), .O_RX_CLK_OUT(rx_clk_out),
		.O_RX_SERIAL_OUT(ser_out), .O_TX_CLK_FROM_REC(from_rec),
		.O_SEND_AIS(send_ais), .O_SEND_FAR_ALARM(send_far),
		.O_CARRIER_LOSS(carrier), .O_CNT_LATCH(cnt_latch),
		.O_COUNT_CV(count_cv), .O_LOCAL_LOOP(local_loop), .O_IRQ(irq));

	// ****************************************************************
	// Bus and frame helpers
	// ****************************************************************
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		cyc(1);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		cyc(1);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		cyc(1);
		addr <= a;
		rd <= 1'b1;
		cyc(1);
		rd <= 1'b0;
		`CHK(rdata, e)
	endtask
	task automatic tick();
		cyc(1);
		tick_s <= 1'b1;
		cyc(1);
		tick_s <= 1'b0;
		cyc(2);
	endtask
	// A new setting only acts after the next frame tick.
	task automatic cfg(input logic [7:0] a, input logic [7:0] d);
		wr_reg(a, d);
		tick();
	endtask
	task automatic chan(input logic [4:0] n, input logic [7:0] d);
		cyc(1);
		chan_stb <= 1'b1;
		chan_num <= n;
		chan_data <= d;
		cyc(1);
		chan_stb <= 1'b0;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_regs();
		rd_chk(CA, 8'h00);
		rd_chk(CL, 8'h00);
		rd_chk(8'h7f, 8'h00);
		addr <= CA;
		wdata <= 8'h5a;
		wr <= 1'b1;
		cyc(1);
		wr <= 1'b0;
		rd <= 1'b1;
		cyc(1);
		rd <= 1'b0;
		`CHK(rdata, 8'h5a)
		wr_reg(CA, 8'h41);
		rd_chk(CA, 8'h41);
		`CHK(from_rec, 1'b0)
		`CHK(count_cv, 1'b0)
		tick();
		`CHK(from_rec, 1'b1)
		`CHK(count_cv, 1'b1)
		cfg(CA, 8'h00);
		`CHK(count_cv, 1'b0)
		$display("test regs done");
	endtask
	task automatic t_clk();
		tx_run <= 1'b0;
		cyc(200);
		`CHK(from_rec, 1'b0)
		tx_run <= 1'b1;
		// Let the restarted clock clear the loss flag before enabling.
		cyc(20);
		cfg(CA, 8'h04);
		`CHK(from_rec, 1'b0)
		tx_run <= 1'b0;
		for (int i = 0; i < 300 && from_rec !== 1'b1; i++) cyc(1);
		`CHK(from_rec, 1'b1)
		tx_run <= 1'b1;
		cfg(CA, 8'h00);
		$display("test clock fallback done");
	endtask
	task automatic t_alarms();
		for (int i = 0; i < 4; i++) begin
			cfg(CA, (i > 1) ? 8'h30 : 8'h00);
			rx_alarm <= i[0] ? 4'b1000 : 4'b0100;
			cyc(3);
			`CHK(send_ais, i > 1)
			`CHK(send_far, i > 1)
			rx_alarm <= '0;
			cyc(3);
			`CHK(send_ais, 1'b0)
		end
		cfg(CA, 8'h10);
		crc4_en <= 1'b1;
		rx_alarm <= 4'b0010;
		cyc(10);
		`CHK(send_far, 1'b0)
		cyc(20);
		`CHK(send_far, 1'b1)
		cyc(30);
		rd_chk(REG_LIVE_STATE, 8'h08);
		`CHK(send_far, 1'b1)
		rx_alarm <= 4'b0011;
		cyc(3);
		`CHK(send_far, 1'b0)
		crc4_en <= 1'b0;
		rx_alarm <= '0;
		$display("test alarms done");
	endtask
	task automatic t_serial();
		cfg(CA, 8'h08);
		rx_alarm <= 4'b1000;
		cyc(3);
		`CHK(ser_out, 1'b1)
		rx_alarm <= '0;
		cyc(3);
		`CHK(ser_out, 1'b0)
		rx_ser <= 1'b1;
		cyc(3);
		`CHK(ser_out, 1'b1)
		rx_ser <= 1'b0;
		cfg(CA, 8'h00);
		rx_alarm <= 4'b1000;
		cyc(3);
		`CHK(ser_out, 1'b0)
		rx_alarm <= '0;
		$display("test serial done");
	endtask
	task automatic t_interval();
		for (int i = 0; i < 2; i++) begin
			cfg(CA, i ? 8'h80 : 8'h00);
			repeat (20) tick();
			latches = 0;
			repeat (20) tick();
			`CHK(latches, i ? 4 : 1)
		end
		$display("test interval done");
	endtask
	task automatic t_carrier();
		cfg(CA, 8'h30);
		wr_reg(REG_EVENT_MASK, 8'h00);
		wr_reg(REG_EVENT_STATUS, 8'h0f);
		zeros <= 1'b1;
		cyc(1940);
		`CHK(carrier, 1'b0)
		cyc(1000);
		`CHK(carrier, 1'b1)
		`CHK(send_ais, 1'b1)
		`CHK(send_far, 1'b1)
		`CHK(irq, 1'b0)
		rd_chk(REG_EVENT_STATUS, 8'h01);
		wr_reg(REG_EVENT_MASK, 8'h01);
		cyc(1);
		`CHK(irq, 1'b1)
		wr_reg(REG_EVENT_STATUS, 8'h01);
		cyc(1);
		`CHK(irq, 1'b0)
		zeros <= 1'b0;
		cyc(300);
		cfg(CA, 8'h02);
		zeros <= 1'b1;
		cyc(2940);
		`CHK(carrier, 1'b0)
		cyc(18000);
		`CHK(carrier, 1'b1)
		cfg(CA, 8'h00);
		$display("test carrier done");
	endtask
	task automatic t_loops();
		tx_fmt <= 2'b11;
		cfg(CL, 8'h00);
		`CHK(tx_line, 2'b11)
		cfg(CL, 8'h80);
		`CHK(tx_line, 2'b00)
		`CHK(rx_frm, 2'b00)
		cfg(CL, 8'h40);
		`CHK(tx_line, 2'b11)
		`CHK(rx_frm, 2'b11)
		`CHK(local_loop, 1'b1)
		tx_fmt <= 2'b00;
		cfg(CL, 8'ha0);
		for (int i = 0; i < 3; i++) begin
			`CHK(tx_line.pos ^ tx_line.neg, 1'b1)
			cyc(10);
		end
		cfg(CL, 8'h03);
		chan(5'h03, 8'ha5);
		chan(5'h04, 8'h3c);
		rd_chk(REG_TX_MONITOR, 8'ha5);
		cfg(CL, 8'h13);
		chan(5'h13, 8'h5a);
		rd_chk(REG_TX_MONITOR, 8'h5a);
		$display("test loops done");
	endtask
	// The frozen transmit clock tells its copy apart from the recovered one.
	task automatic t_framer();
		tx_run <= 1'b0;
		tx_fmt <= 2'b10;
		frm_loop <= 1'b1;
		cyc(8);
		`CHK(rx_frm, 2'b10)
		`CHK(tx_line, 2'b10)
		for (int i = 0; i < 4; i++) begin
			`CHK(rx_clk_out, tx_clk)
			cyc(3);
		end
		frm_loop <= 1'b0;
		tx_run <= 1'b1;
		cyc(3);
		`CHK(rx_frm, 2'b00)
		$display("test framer loop done");
	endtask

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// The tests need about 25,000 cycles; the limit allows nearly twice that.
	initial begin
		#1_000_000;
		n_errors++;
		tally_and_finish();
	end

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		cyc(1);
		t_regs();
		t_clk();
		t_alarms();
		t_serial();
		t_interval();
		t_carrier();
		t_loops();
		t_framer();
		tally_and_finish();
	end
endmodule
`default_nettype wire
